// ==== shared/blsd_regs.svh ====
// Constants of the byte link codec: symbols, widths, timing counts
`ifndef BLSD_REGS_SVH
`define BLSD_REGS_SVH

`define BLSD_CLK_PERIOD_NS   10
`define BLSD_BYTE_PERIOD_NS  100
`define BLSD_BYTE_CYCLES     (`BLSD_BYTE_PERIOD_NS / `BLSD_CLK_PERIOD_NS)

`define BLSD_SYM_W           10
`define BLSD_NIB_W           5
`define BLSD_DATA_W          8
`define BLSD_CMD_W           4
`define BLSD_WORD_W          12
`define BLSD_CNT_W           4
`define BLSD_CNT_LAST        4'h9
`define BLSD_CNT_HALF        4'h5
`define BLSD_FIFO_DEPTH      16

`define BLSD_MODE_8BIT       2'h0
`define BLSD_CMD_NONE        4'h0
`define BLSD_CMD_QUIET       4'hF

`define BLSD_SYM_Q           5'h00
`define BLSD_SYM_H           5'h04
`define BLSD_SYM_I           5'h1F
`define BLSD_SYM_T           5'h0D
`define BLSD_SYM_R           5'h07
`define BLSD_SYM_S           5'h19
`define BLSD_SYM_J           5'h18
`define BLSD_SYM_K           5'h11
`define BLSD_SYNC            10'h311

`endif

// ==== shared/blsd_pkg.sv ====
// Types of the byte link codec
package blsd_pkg;
`include "blsd_regs.svh"

   typedef struct packed {
      logic                      strbPrev;
      logic                      hold0V;
      logic                      hold1V;
      logic [`BLSD_WORD_W-1:0]   hold0;
      logic [`BLSD_WORD_W-1:0]   hold1;
      logic                      ackOut;
      logic [`BLSD_CNT_W-1:0]    txCnt;
      logic [`BLSD_SYM_W-1:0]    txShift;
      logic                      txLine;
      logic                      byteClk;
      logic                      rxPrev;
      logic [`BLSD_SYM_W-1:0]    rxShift;
      logic [`BLSD_CNT_W-1:0]    rxCnt;
      logic                      framed;
      logic [`BLSD_DATA_W-1:0]   rxData;
      logic [`BLSD_CMD_W-1:0]    rxCmd;
      logic                      dStrobe;
      logic                      cStrobe;
      logic                      viol;
   } blsd_state_s;

endpackage : blsd_pkg

// ==== core/blsd_codec.sv ====
// Byte link transmitter and receiver with a FIFO between input buffer and serializer
`timescale 1ns/10ps
`include "blsd_regs.svh"

module blsd_fifo #(
   parameter int WIDTH = `BLSD_WORD_W,
   parameter int DEPTH = `BLSD_FIFO_DEPTH
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
      logic                        inRdy;
   } blsd_fifo_s;

   localparam blsd_fifo_s RST = '{mem: '0, wr: '0, rd: '0, cnt: '0, inRdy: 1'b1};

   blsd_fifo_s s;
   blsd_fifo_s n;
   logic       push;
   logic       pop;

   // Depth must be a power of two so the pointers wrap by themselves
   always_comb begin
      n = s;
      push = inValid & s.inRdy;
      pop = outReady & (s.cnt != '0);
      if (push) begin
         n.mem[s.wr] = inData;
         n.wr = s.wr + 1'b1;
      end
      if (pop) begin
         n.rd = s.rd + 1'b1;
      end
      unique case ({push, pop})
         2'b10: n.cnt = s.cnt + 1'b1;
         2'b01: n.cnt = s.cnt - 1'b1;
         default: n.cnt = s.cnt;
      endcase
      n.inRdy = (n.cnt != FULL);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= RST;
      end else begin
         s <= n;
      end
   end

   assign inReady = s.inRdy;
   assign outValid = (s.cnt != '0);
   assign outData = s.mem[s.rd];
endmodule : blsd_fifo

module blsd_codec (
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic                    dataStrobeIn,
   input  wire logic [`BLSD_DATA_W-1:0] txDataIn,
   input  wire logic [`BLSD_CMD_W-1:0]  txCmdIn,
   output logic                         txAck,
   output logic                         serialLineOut,
   output logic                         byteClockOut,
   input  wire logic                    serialLineIn,
   input  wire logic [1:0]              rxMode,
   output logic [`BLSD_DATA_W-1:0]      rxDataOut,
   output logic [`BLSD_CMD_W-1:0]       rxCmdOut,
   output logic                         dataStrobeOut,
   output logic                         commandStrobeOut,
   output logic                         violationFlag
);
   blsd_pkg::blsd_state_s s;
   blsd_pkg::blsd_state_s n;

   logic                      rise;
   logic                      load;
   logic                      txBit;
   logic                      rxBit;
   logic                      syncHit;
   logic                      groupEnd;
   logic [`BLSD_SYM_W-1:0]    sym;
   logic [`BLSD_SYM_W-1:0]    rxGroup;
   logic [`BLSD_WORD_W-1:0]   inWord;
   logic                      fifoInReady;
   logic                      fifoOutValid;
   logic [`BLSD_WORD_W-1:0]   fifoOutData;
   logic [4:0]                hiDec;
   logic [4:0]                loDec;
   logic [4:0]                cmdDec;

   // Data nibble code; no code leaves more than three bit times without a transition
   function automatic logic [4:0] enc5(input logic [3:0] nib);
      unique case (nib)
         4'h0: return 5'h1E;
         4'h1: return 5'h09;
         4'h2: return 5'h14;
         4'h3: return 5'h15;
         4'h4: return 5'h0A;
         4'h5: return 5'h0B;
         4'h6: return 5'h0E;
         4'h7: return 5'h0F;
         4'h8: return 5'h12;
         4'h9: return 5'h13;
         4'hA: return 5'h16;
         4'hB: return 5'h17;
         4'hC: return 5'h1A;
         4'hD: return 5'h1B;
         4'hE: return 5'h1C;
         4'hF: return 5'h1D;
      endcase
   endfunction : enc5

   function automatic logic [4:0] dec5(input logic [4:0] code);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (enc5(4'(i)) == code) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction : dec5

   // Command pairs; A and D are the halt/quiet pairs, 8 is halt/halt, F is all quiet
   function automatic logic [`BLSD_SYM_W-1:0] cmdSym(input logic [3:0] c);
      unique case (c)
         4'h1: return {`BLSD_SYM_I, `BLSD_SYM_T};
         4'h2: return {`BLSD_SYM_I, `BLSD_SYM_R};
         4'h3: return {`BLSD_SYM_I, `BLSD_SYM_S};
         4'h4: return {`BLSD_SYM_T, `BLSD_SYM_I};
         4'h5: return {`BLSD_SYM_T, `BLSD_SYM_T};
         4'h6: return {`BLSD_SYM_T, `BLSD_SYM_R};
         4'h7: return {`BLSD_SYM_T, `BLSD_SYM_S};
         4'h8: return {`BLSD_SYM_H, `BLSD_SYM_H};
         4'h9: return {`BLSD_SYM_R, `BLSD_SYM_I};
         4'hA: return {`BLSD_SYM_H, `BLSD_SYM_Q};
         4'hB: return {`BLSD_SYM_R, `BLSD_SYM_T};
         4'hC: return {`BLSD_SYM_R, `BLSD_SYM_R};
         4'hD: return {`BLSD_SYM_Q, `BLSD_SYM_H};
         4'hE: return {`BLSD_SYM_R, `BLSD_SYM_S};
         4'hF: return {`BLSD_SYM_Q, `BLSD_SYM_Q};
         4'h0: return `BLSD_SYNC;
      endcase
   endfunction : cmdSym

   function automatic logic [4:0] cmdFind(input logic [`BLSD_SYM_W-1:0] g);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 1; i < 16; i++) begin
         if (cmdSym(4'(i)) == g) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction : cmdFind

   // Sixteen words decouple strobe bursts from the fixed slot rate
   blsd_fifo #(
      .WIDTH (`BLSD_WORD_W),
      .DEPTH (`BLSD_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .inValid  (s.hold0V),
      .inReady  (fifoInReady),
      .inData   (s.hold0),
      .outValid (fifoOutValid),
      .outReady (load),
      .outData  (fifoOutData)
   );

   always_comb begin
      n = s;
      inWord = {txCmdIn, txDataIn};
      rise = dataStrobeIn & ~s.strbPrev;
      n.strbPrev = dataStrobeIn;
      // Input buffer: holding stage drains into the FIFO, extra stage moves up
      if (s.hold0V && fifoInReady) begin
         n.hold0V = s.hold1V;
         n.hold0 = s.hold1;
         n.hold1V = 1'b0;
      end
      if (rise) begin
         if (!n.hold0V) begin
            n.hold0V = 1'b1;
            n.hold0 = inWord;
         end else if (!n.hold1V) begin
            n.hold1V = 1'b1;
            n.hold1 = inWord;
         end
      end
      // Acknowledge drops once both stages are taken
      n.ackOut = ~(n.hold0V & n.hold1V);

      // Serializer, one bit per clock, ten bits per slot
      load = (s.txCnt == `BLSD_CNT_LAST);
      sym = `BLSD_SYNC;
      if (fifoOutValid) begin
         if (fifoOutData[11:8] != `BLSD_CMD_NONE) begin
            sym = cmdSym(fifoOutData[11:8]);
         end else begin
            sym = {enc5(fifoOutData[7:4]), enc5(fifoOutData[3:0])};
         end
      end
      txBit = load ? sym[`BLSD_SYM_W-1] : s.txShift[`BLSD_SYM_W-1];
      n.txShift = load ? {sym[8:0], 1'b0} : {s.txShift[8:0], 1'b0};
      // A one toggles the line, so an all-zero pair leaves it at whatever level it had
      n.txLine = s.txLine ^ txBit;
      n.txCnt = load ? '0 : s.txCnt + 4'h1;
      n.byteClk = (n.txCnt < `BLSD_CNT_HALF);

      // Receiver
      rxBit = serialLineIn ^ s.rxPrev;
      n.rxPrev = serialLineIn;
      rxGroup = {s.rxShift[8:0], rxBit};
      n.rxShift = rxGroup;
      syncHit = (rxGroup == `BLSD_SYNC);
      groupEnd = (s.rxCnt == `BLSD_CNT_LAST) && !syncHit;
      hiDec = dec5(rxGroup[9:5]);
      loDec = dec5(rxGroup[4:0]);
      cmdDec = cmdFind(rxGroup);
      n.dStrobe = 1'b0;
      n.cStrobe = 1'b0;
      if (syncHit) begin
         n.rxCnt = '0;
         n.framed = 1'b1;
         n.viol = 1'b0;
      end else begin
         n.rxCnt = groupEnd ? '0 : s.rxCnt + 4'h1;
      end
      // Without framing a line-state pair may sit at any bit offset, so nothing is decoded
      if (groupEnd && s.framed) begin
         // Each group stands alone; repeated line-state pairs are not counted
         n.viol = 1'b0;
         if (hiDec[4] && loDec[4]) begin
            n.dStrobe = 1'b1;
            n.rxData = {hiDec[3:0], loDec[3:0]};
         end else if (cmdDec[4] && (cmdDec[3:0] != `BLSD_CMD_QUIET)) begin
            n.cStrobe = 1'b1;
            n.rxCmd = cmdDec[3:0];
         end else if (cmdDec[4]) begin
            n.cStrobe = 1'b1;
            n.rxCmd = `BLSD_CMD_QUIET;
            n.viol = (rxMode != `BLSD_MODE_8BIT);
         end else begin
            n.viol = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign txAck = s.ackOut;
   assign serialLineOut = s.txLine;
   assign byteClockOut = s.byteClk;
   assign rxDataOut = s.rxData;
   assign rxCmdOut = s.rxCmd;
   assign dataStrobeOut = s.dStrobe;
   assign commandStrobeOut = s.cStrobe;
   assign violationFlag = s.viol;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   property p_strobe_latch;
      (rise && !s.hold0V) |=> (s.hold0V && s.hold0 == $past(inWord));
   endproperty
   a_strobe_latch: assert property (p_strobe_latch)
      else $error("strobed word not latched");

   property p_slot_pop;
      (load && fifoOutValid) |=> (s.txShift == {$past(sym[8:0]), 1'b0} && $past(sym) != `BLSD_SYNC);
   endproperty
   a_slot_pop: assert property (p_slot_pop)
      else $error("pending word not sent in slot");

   property p_no_overrun;
      (rise && s.ackOut) |-> !(s.hold0V && s.hold1V);
   endproperty
   a_no_overrun: assert property (p_no_overrun)
      else $error("acknowledge high with full buffer");

   property p_pad_sync;
      (load && !fifoOutValid) |=> (s.txShift == {9'h111, 1'b0} && s.txCnt == 4'h0);
   endproperty
   a_pad_sync: assert property (p_pad_sync)
      else $error("empty slot not padded with sync");

   property p_quiet_line;
      (load && fifoOutValid && fifoOutData[11:8] == `BLSD_CMD_QUIET) |=>
         $stable(serialLineOut) [*8];
   endproperty
   a_quiet_line: assert property (p_quiet_line)
      else $error("quiet command toggled the line");

   property p_sync_frame;
      syncHit |=> (s.rxCnt == 4'h0 && s.framed && !violationFlag);
   endproperty
   a_sync_frame: assert property (p_sync_frame)
      else $error("sync did not reset bit counter");

   property p_need_frame;
      (dataStrobeOut || commandStrobeOut || violationFlag) |-> $past(s.framed);
   endproperty
   a_need_frame: assert property (p_need_frame)
      else $error("decode output without framing");

   property p_halt_quiet;
      (groupEnd && s.framed && rxGroup == 10'h080) |=> (commandStrobeOut && rxCmdOut == 4'hA);
   endproperty
   a_halt_quiet: assert property (p_halt_quiet)
      else $error("halt quiet pair not decoded as A");

   property p_quiet_in;
      (groupEnd && s.framed && rxGroup == 10'h000) |=>
         (commandStrobeOut && rxCmdOut == 4'hF && violationFlag == ($past(rxMode) != 2'h0));
   endproperty
   a_quiet_in: assert property (p_quiet_in)
      else $error("quiet line decoded wrongly for mode");

   property p_viol_hold;
      $rose(violationFlag) |-> violationFlag [*8];
   endproperty
   a_viol_hold: assert property (p_viol_hold)
      else $error("violation not held for the byte period");
endmodule : blsd_codec

// ==== sim/blsd_host_model.sv ====
// Host model that strobes queued words into the transmitter
`timescale 1ns/10ps
module blsd_host_model (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        txAck,
   output logic             dataStrobeIn,
   output logic [7:0]       txDataIn,
   output logic [3:0]       txCmdIn
);
   logic [11:0] wordQ[$];
   int          cyc = 0;
   int          last1 = -100;
   int          last2 = -100;

   task automatic push(input logic [11:0] w);
      wordQ.push_back(w);
   endtask : push

   initial begin
      dataStrobeIn = 1'b0;
      txDataIn = 8'h00;
      txCmdIn = 4'h0;
   end

   // Strobes on the falling edge, half a clock away from the rising edge where the codec samples
   always @(negedge ref_clk) begin
      cyc <= cyc + 1;
      if (dataStrobeIn) begin
         dataStrobeIn <= 1'b0;
         // Released bus shows the inverse, not a stale word
         txDataIn <= ~txDataIn;
         txCmdIn <= ~txCmdIn;
      end else if (rst_n && txAck && wordQ.size() > 0
                   && cyc - last2 >= 10
                   && !(last1 - last2 < 10 && cyc - last1 < 20)) begin
         {txCmdIn, txDataIn} <= wordQ.pop_front();
         dataStrobeIn <= 1'b1;
         last2 <= last1;
         last1 <= cyc;
      end
   end
endmodule : blsd_host_model

// ==== sim/blsd_codec_tb.sv ====
// Bench: loopback traffic, then a directly driven receiver line
`timescale 1ns/10ps
module blsd_codec_tb;
   logic        ref_clk;
   logic        rst_n;
   logic        dataStrobeIn;
   logic [7:0]  txDataIn;
   logic [3:0]  txCmdIn;
   logic        txAck;
   logic        serialLineOut;
   logic        byteClockOut;
   logic        serialLineIn;
   logic        loopOn;
   logic        drvLine;
   logic        quietOk;
   logic [1:0]  rxMode;
   logic [7:0]  rxDataOut;
   logic [3:0]  rxCmdOut;
   logic        dataStrobeOut;
   logic        commandStrobeOut;
   logic        violationFlag;
   logic [11:0] expQ[$];
   logic [11:0] w;
   int          fails;
   int          n_compared;
   int          cycles;
   int          quietSeen;
   int          tg;
   int          mr;
   int          hiCnt;

   assign serialLineIn = loopOn ? serialLineOut : drvLine;

   blsd_codec dut (.ref_clk(ref_clk), .rst_n(rst_n), .dataStrobeIn(dataStrobeIn),
      .txDataIn(txDataIn), .txCmdIn(txCmdIn), .txAck(txAck), .serialLineOut(serialLineOut),
      .byteClockOut(byteClockOut), .serialLineIn(serialLineIn), .rxMode(rxMode),
      .rxDataOut(rxDataOut), .rxCmdOut(rxCmdOut), .dataStrobeOut(dataStrobeOut),
      .commandStrobeOut(commandStrobeOut), .violationFlag(violationFlag));

   blsd_host_model host (.ref_clk(ref_clk), .rst_n(rst_n), .txAck(txAck),
      .dataStrobeIn(dataStrobeIn), .txDataIn(txDataIn), .txCmdIn(txCmdIn));

   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   // Every strobe except a command strobe once quietOk is set, which must be quiet, is matched against the queue; a strobe with nothing queued is a fault
   always @(negedge ref_clk) begin
      if (quietOk && commandStrobeOut === 1'b1) begin
         chk("quietCmd", {rxCmdOut, 8'h00}, 12'hF00);
         quietSeen++;
      end else if (dataStrobeOut === 1'b1 || commandStrobeOut === 1'b1) begin
         if (expQ.size() == 0) begin
            chk("spareStrobe", 12'h001, 12'h000);
         end else begin
            w = expQ.pop_front();
            if (dataStrobeOut === 1'b1) chk("rxData", {4'h0, rxDataOut}, w);
            else chk("rxCmd", {rxCmdOut, 8'h00}, {w[11:8], 8'h00});
         end
      end
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         test_done();
      end
   end

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
   endtask : do_reset

   task automatic send(input logic [11:0] v);
      expQ.push_back(v);
      host.push(v);
   endtask : send

   task automatic wait_drain();
      int n;
      n = 0;
      while (expQ.size() != 0 && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      chk("drained", 12'(expQ.size()), 12'h000);
   endtask : wait_drain

   // Toggles and longest steady run of the serial output over n cycles
   task automatic count_run(input int n, output int toggles, output int maxRun);
      logic prev;
      int   run;
      prev = serialLineOut;
      run = 1;
      toggles = 0;
      maxRun = 1;
      repeat (n) begin
         @(negedge ref_clk);
         if (serialLineOut !== prev) begin
            toggles++;
            run = 1;
         end else begin
            run++;
         end
         if (run > maxRun) maxRun = run;
         prev = serialLineOut;
      end
   endtask : count_run

   // NRZI: a one bit toggles the driven line
   task automatic rx_sym(input logic [9:0] sym);
      for (int i = 9; i >= 0; i--) begin
         @(negedge ref_clk);
         if (sym[i]) drvLine = ~drvLine;
      end
   endtask : rx_sym

   task automatic t_idle();
      repeat (40) @(negedge ref_clk);
      count_run(20, tg, mr);
      chk("idleToggles", 12'(tg), 12'h008);
      chk("idleViol", {11'h000, violationFlag}, 12'h000);
      hiCnt = 0;
      repeat (20) begin
         @(negedge ref_clk);
         if (byteClockOut === 1'b1) hiCnt++;
      end
      chk("byteClkHigh", 12'(hiCnt), 12'h00A);
   endtask : t_idle

   task automatic t_data();
      send(12'h000);
      send(12'h0FF);
      send(12'h05A);
      send(12'h0A5);
      send(12'h03C);
      count_run(60, tg, mr);
      chk("dataRun", 12'(mr <= 4), 12'h001);
      wait_drain();
      repeat (4) @(negedge ref_clk);
      chk("ackFree", {11'h000, txAck}, 12'h001);
   endtask : t_data

   task automatic t_cmds();
      send(12'hA00);
      send(12'hD00);
      send(12'h800);
      wait_drain();
   endtask : t_cmds

   task automatic t_quiet_tx();
      send(12'hF00);
      count_run(80, tg, mr);
      chk("quietRun", 12'(mr >= 10), 12'h001);
      wait_drain();
   endtask : t_quiet_tx

   task automatic t_direct();
      loopOn = 1'b0;
      do_reset();
      rx_sym(10'h080);
      rx_sym(10'h004);
      repeat (3) @(negedge ref_clk);
      chk("unframedViol", {11'h000, violationFlag}, 12'h000);
      rx_sym(10'h311);
      expQ = {12'hA00, 12'hA00, 12'hD00, 12'h800};
      rx_sym(10'h080);
      rx_sym(10'h080);
      rx_sym(10'h004);
      rx_sym(10'h084);
      rx_sym(10'h040);
      repeat (2) @(negedge ref_clk);
      chk("badGroup", {11'h000, violationFlag}, 12'h001);
      chk("pairsSeen", 12'(expQ.size()), 12'h000);
      rx_sym(10'h311);
      quietOk = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("syncClears", {11'h000, violationFlag}, 12'h000);
      repeat (25) @(negedge ref_clk);
      chk("quietStrobes", 12'(quietSeen > 0), 12'h001);
      chk("quietViol8", {11'h000, violationFlag}, 12'h000);
      rxMode = 2'h1;
      repeat (15) @(negedge ref_clk);
      chk("quietViol10", {11'h000, violationFlag}, 12'h001);
   endtask : t_direct

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      rst_n = 1'b0;
      loopOn = 1'b1;
      drvLine = 1'b0;
      quietOk = 1'b0;
      rxMode = 2'h0;
      fails = 0;
      n_compared = 0;
      cycles = 0;
      quietSeen = 0;
      do_reset();
      t_idle();
      t_data();
      t_cmds();
      t_quiet_tx();
      t_direct();
      test_done();
   end
endmodule : blsd_codec_tb
